// File: verilog/dpa_pkg.sv
package dpa_pkg;
  // ==========================================================
  // command encoding (cs_n, ras_n, cas_n, we_n)
  localparam logic [3:0] DPA_CMD_NOP = 4'h7;
  localparam logic [3:0] DPA_CMD_ACT = 4'h3;
  localparam logic [3:0] DPA_CMD_PRE = 4'h2;
  localparam logic [3:0] DPA_CMD_RD = 4'h5;
  localparam logic [3:0] DPA_CMD_WR = 4'h4;
  localparam logic [3:0] DPA_CMD_DESEL = 4'hF;
  // ==========================================================
  // geometry and timing (clocks at 10 MHz, tCK 100 ns)
  localparam int DPA_BANKS = 4;
  localparam int DPA_BA_W = 2;
  localparam int DPA_AP_BIT = 10;
  localparam int DPA_ADDR_W = 13;
  localparam int DPA_CNT_W = 8;
  localparam int DPA_TCK_NS = 100;
  localparam int DPA_TRTP_NS = 8;
  localparam int DPA_TRP_NS = 15;
  localparam int DPA_TRAS_NS = 45;
  localparam int DPA_TRC_NS = 60;
  localparam int DPA_TWR_NS = 15;
  localparam int DPA_RTP_CLK = (DPA_TRTP_NS + DPA_TCK_NS - 1) / DPA_TCK_NS;
  localparam int DPA_RP_CLK = (DPA_TRP_NS + DPA_TCK_NS - 1) / DPA_TCK_NS;
  localparam int DPA_RAS_CLK = (DPA_TRAS_NS + DPA_TCK_NS - 1) / DPA_TCK_NS;
  localparam int DPA_RC_CLK = (DPA_TRC_NS + DPA_TCK_NS - 1) / DPA_TCK_NS;
  localparam int DPA_WR_CLK = (DPA_TWR_NS + DPA_TCK_NS - 1) / DPA_TCK_NS;
  localparam int DPA_MIN_GAP = 2;
  localparam int DPA_BL8_SHIFT = 2;
  localparam int DPA_AL = 0;
  localparam int DPA_CL = 3;
  localparam int DPA_BL = 4;
  localparam logic [DPA_CNT_W-1:0] DPA_CNT_ONE = 8'h01;
  localparam logic [DPA_CNT_W-1:0] DPA_CNT_ZERO = 8'h00;
endpackage

// File: verilog/dpa_link_if.sv
`timescale 1ns/10ps
interface dpa_link_if;
  import dpa_pkg::*;
  logic [3:0] cmd;
  logic [DPA_BA_W-1:0] ba;
  logic [DPA_ADDR_W-1:0] addr;
  logic [DPA_BANKS-1:0] bank_open;
  logic [DPA_BANKS-1:0] ap_pending;
  logic cmd_error;
  modport ctrl (output cmd, output ba, output addr, input bank_open, input ap_pending,
    input cmd_error);
  modport mem (input cmd, input ba, input addr, output bank_open, output ap_pending,
    output cmd_error);
endinterface

// File: verilog/dpa_sdram_bank.sv
`timescale 1ns/10ps
// Functional notes
// - A10 low closes one bank, high all
// - read to precharge spacing honored by controller
// - activate waits tRP after precharge
// - explicit precharge waits tRAS after activate
// - write to precharge WL+BL/2+tWR
// - A10 low read/write leaves bank open
// - A10 high read/write arms auto-precharge
// - write auto-precharge waits for last data
// - auto-precharge held off until tRAS met
// - read auto-precharge at AL+BL/2, postponed if needed
// - tRP starts where tRTP ends
// - never earlier than two clocks after prefetch
// - reactivate after tRP and tRC
// - write auto-precharge after burst plus WR
// - write auto-precharge reactivate after WR+tRP, tRC
// - precharge after autoprecharge uses same spacings
// - precharge may follow precharge by one clock
// - RTP equals tRTP over tCK rounded up
// - tRP counted from latest precharge to bank
// - timing uses programmed burst length
module dpa_sdram_bank
  import dpa_pkg::*;
#(
  parameter int AL = DPA_AL,
  parameter int CL = DPA_CL,
  parameter int BL = DPA_BL
)(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // command link
  dpa_link_if.mem link,
  // status
  output logic [DPA_BANKS-1:0] bank_open_out,
  output logic [DPA_BANKS-1:0] precharging_out,
  output logic cmd_error_out
);
  // ==========================================================
  // auto-precharge delays from the read/write command
  localparam int WL = AL + CL - 1;
  localparam int PREF = AL + ((BL == 8) ? DPA_BL8_SHIFT : 0);
  localparam int RD_AP = AL + BL / 2;
  localparam int RD_MIN = PREF + DPA_MIN_GAP;
  localparam int RD_RTP = PREF + DPA_RTP_CLK;
  localparam int RD_DLY = (RD_AP > RD_MIN) ? ((RD_AP > RD_RTP) ? RD_AP : RD_RTP)
    : ((RD_MIN > RD_RTP) ? RD_MIN : RD_RTP);
  localparam int WR_DLY = WL + BL / 2 + DPA_WR_CLK;
  localparam logic [DPA_CNT_W-1:0] RD_DLY_C = DPA_CNT_W'(RD_DLY);
  localparam logic [DPA_CNT_W-1:0] WR_DLY_C = DPA_CNT_W'(WR_DLY);
  localparam logic [DPA_CNT_W-1:0] RAS_C = DPA_CNT_W'(DPA_RAS_CLK);
  localparam logic [DPA_CNT_W-1:0] RP_C = DPA_CNT_W'(DPA_RP_CLK);
  // ==========================================================
  // precharge and activate spacings the memory polices
  localparam int RTP2 = (DPA_RTP_CLK > DPA_MIN_GAP) ? DPA_RTP_CLK : DPA_MIN_GAP;
  localparam int RD_PRE = AL + BL / 2 + RTP2 - DPA_MIN_GAP;
  localparam int WR_PRE = WL + BL / 2 + DPA_WR_CLK;
  localparam logic [DPA_CNT_W-1:0] RD_PRE_C = DPA_CNT_W'(RD_PRE);
  localparam logic [DPA_CNT_W-1:0] WR_PRE_C = DPA_CNT_W'(WR_PRE);
  localparam logic [DPA_CNT_W-1:0] RC_C = DPA_CNT_W'(DPA_RC_CLK);
  // ==========================================================
  // command decode
  logic is_act;
  logic is_pre;
  logic is_rw;
  logic ap_flag;
  always_comb
  begin
    is_act = (link.cmd == DPA_CMD_ACT);
    is_pre = (link.cmd == DPA_CMD_PRE);
    is_rw = (link.cmd == DPA_CMD_RD) || (link.cmd == DPA_CMD_WR);
    ap_flag = link.addr[DPA_AP_BIT];
  end
  // ==========================================================
  // per-bank state
  logic [DPA_BANKS-1:0] open_reg, open_next;
  logic [DPA_BANKS-1:0] ap_reg, ap_next;
  logic [DPA_CNT_W-1:0] ras_reg [DPA_BANKS], ras_next [DPA_BANKS];
  logic [DPA_CNT_W-1:0] apc_reg [DPA_BANKS], apc_next [DPA_BANKS];
  logic [DPA_CNT_W-1:0] rp_reg [DPA_BANKS], rp_next [DPA_BANKS];
  logic [DPA_BANKS-1:0] err_b;
  logic [DPA_CNT_W-1:0] hold_reg [DPA_BANKS], hold_next [DPA_BANKS];
  logic [DPA_CNT_W-1:0] rc_reg [DPA_BANKS], rc_next [DPA_BANKS];
  logic [DPA_BANKS-1:0] err_t;
  logic err_reg, err_next;
  genvar g;
  generate
    for (g = 0; g < DPA_BANKS; g++)
    begin : g_bank
      logic sel;
      logic close_pre;
      logic ap_fire;
      logic access_ok;
      logic hold_bad;
      logic rc_bad;
      always_comb
      begin
        sel = (link.ba == DPA_BA_W'(g));
        close_pre = is_pre && (ap_flag || sel);
        // a count of one means the delay ends at this very edge
        ap_fire = ap_reg[g] && (apc_reg[g] <= DPA_CNT_ONE)
          && (ras_reg[g] <= DPA_CNT_ONE);
        access_ok = is_rw && sel && open_reg[g] && !ap_reg[g];
        open_next[g] = open_reg[g];
        ap_next[g] = ap_reg[g];
        ras_next[g] = (ras_reg[g] != DPA_CNT_ZERO) ? ras_reg[g] - DPA_CNT_ONE : ras_reg[g];
        apc_next[g] = (apc_reg[g] != DPA_CNT_ZERO) ? apc_reg[g] - DPA_CNT_ONE : apc_reg[g];
        rp_next[g] = (rp_reg[g] != DPA_CNT_ZERO) ? rp_reg[g] - DPA_CNT_ONE : rp_reg[g];
        err_b[g] = 1'b0;
        if (ap_fire)
        begin
          open_next[g] = 1'b0;
          ap_next[g] = 1'b0;
          rp_next[g] = RP_C;
        end
        if (is_act && sel)
        begin
          err_b[g] = open_reg[g] || ap_reg[g] || (rp_reg[g] > DPA_CNT_ONE);
          open_next[g] = 1'b1;
          ras_next[g] = RAS_C;
        end
        if (is_rw && sel && open_reg[g] && !ap_reg[g])
        begin
          if (ap_flag)
          begin
            ap_next[g] = 1'b1;
            apc_next[g] = (link.cmd == DPA_CMD_RD) ? RD_DLY_C : WR_DLY_C;
          end
        end
        if (is_rw && sel && (!open_reg[g] || ap_reg[g]))
          err_b[g] = 1'b1;
        if (close_pre)
        begin
          err_b[g] = err_b[g] | (ap_reg[g] && !ap_fire)
            | (open_reg[g] && (ras_reg[g] > DPA_CNT_ONE));
          open_next[g] = 1'b0;
          ap_next[g] = 1'b0;
          rp_next[g] = RP_C;
        end
      end
      always_ff @(posedge sys_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          open_reg[g] <= 1'b0;
          ap_reg[g] <= 1'b0;
          ras_reg[g] <= DPA_CNT_ZERO;
          apc_reg[g] <= DPA_CNT_ZERO;
          rp_reg[g] <= DPA_CNT_ZERO;
        end
        else
        begin
          open_reg[g] <= open_next[g];
          ap_reg[g] <= ap_next[g];
          ras_reg[g] <= ras_next[g];
          apc_reg[g] <= apc_next[g];
          rp_reg[g] <= rp_next[g];
        end
      end
      assign precharging_out[g] = (rp_reg[g] != DPA_CNT_ZERO);
      // ==========================================================
      // read/write to precharge and activate to activate guards
      always_comb
      begin
        hold_bad = close_pre && (hold_reg[g] > DPA_CNT_ONE);
        rc_bad = is_act && sel && (rc_reg[g] > DPA_CNT_ONE);
        err_t[g] = hold_bad || rc_bad;
        hold_next[g] = (hold_reg[g] != DPA_CNT_ZERO) ? hold_reg[g] - DPA_CNT_ONE : hold_reg[g];
        rc_next[g] = (rc_reg[g] != DPA_CNT_ZERO) ? rc_reg[g] - DPA_CNT_ONE : rc_reg[g];
        if (is_act && sel)
          rc_next[g] = RC_C;
        // keep the later of a running spacing and the new one
        if (access_ok && (link.cmd == DPA_CMD_RD) && (hold_next[g] < RD_PRE_C))
          hold_next[g] = RD_PRE_C;
        if (access_ok && (link.cmd == DPA_CMD_WR) && (hold_next[g] < WR_PRE_C))
          hold_next[g] = WR_PRE_C;
      end
      always_ff @(posedge sys_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          hold_reg[g] <= DPA_CNT_ZERO;
          rc_reg[g] <= DPA_CNT_ZERO;
        end
        else
        begin
          hold_reg[g] <= hold_next[g];
          rc_reg[g] <= rc_next[g];
        end
      end
    end
  endgenerate
  // ==========================================================
  // error flag, one cycle after the offending command
  always_comb
  begin
    err_next = (|err_b) || (|err_t);
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      err_reg <= 1'b0;
    else
      err_reg <= err_next;
  end
  assign bank_open_out = open_reg;
  assign cmd_error_out = err_reg;
  assign link.bank_open = open_reg;
  assign link.ap_pending = ap_reg;
  assign link.cmd_error = err_reg;
endmodule

// File: verilog/dpa_ctrl.sv
`timescale 1ns/10ps
module dpa_ctrl
  import dpa_pkg::*;
#(
  parameter int AL = DPA_AL,
  parameter int CL = DPA_CL,
  parameter int BL = DPA_BL
)(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // user request
  input wire logic req_valid_in,
  input wire logic [3:0] req_cmd_in,
  input wire logic [DPA_BA_W-1:0] req_ba_in,
  input wire logic [DPA_ADDR_W-1:0] req_addr_in,
  output logic req_ready_out,
  // command link
  dpa_link_if.ctrl link
);
  // ==========================================================
  // spacings in clocks
  localparam int WL = AL + CL - 1;
  localparam int RTP2 = (DPA_RTP_CLK > DPA_MIN_GAP) ? DPA_RTP_CLK : DPA_MIN_GAP;
  localparam int RD2PRE = AL + BL / 2 + RTP2 - DPA_MIN_GAP;
  localparam int WR2PRE = WL + BL / 2 + DPA_WR_CLK;
  localparam int PREF = AL + ((BL == 8) ? DPA_BL8_SHIFT : 0);
  localparam int RDAP_ACT = PREF + ((DPA_TRTP_NS + DPA_TRP_NS + DPA_TCK_NS - 1)
    / DPA_TCK_NS);
  localparam int RD_AP = AL + BL / 2 + DPA_RP_CLK;
  localparam int RDAP2 = (RDAP_ACT > RD_AP) ? RDAP_ACT : RD_AP;
  localparam int WRAP_ACT = WR2PRE + DPA_RP_CLK;
  localparam logic [DPA_CNT_W-1:0] C_RD2PRE = DPA_CNT_W'(RD2PRE);
  localparam logic [DPA_CNT_W-1:0] C_WR2PRE = DPA_CNT_W'(WR2PRE);
  localparam logic [DPA_CNT_W-1:0] C_RDAP = DPA_CNT_W'(RDAP2);
  localparam logic [DPA_CNT_W-1:0] C_WRAP = DPA_CNT_W'(WRAP_ACT);
  localparam logic [DPA_CNT_W-1:0] C_RAS = DPA_CNT_W'(DPA_RAS_CLK);
  localparam logic [DPA_CNT_W-1:0] C_RC = DPA_CNT_W'(DPA_RC_CLK);
  localparam logic [DPA_CNT_W-1:0] C_RP = DPA_CNT_W'(DPA_RP_CLK);
  // ==========================================================
  // per-bank guards: earliest precharge and earliest activate
  logic [DPA_CNT_W-1:0] pre_reg [DPA_BANKS], pre_next [DPA_BANKS];
  logic [DPA_CNT_W-1:0] act_reg [DPA_BANKS], act_next [DPA_BANKS];
  logic [DPA_BANKS-1:0] ok_b;
  logic is_pre;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic ap;
  logic go;
  always_comb
  begin
    is_pre = (req_cmd_in == DPA_CMD_PRE);
    is_act = (req_cmd_in == DPA_CMD_ACT);
    is_rd = (req_cmd_in == DPA_CMD_RD);
    is_wr = (req_cmd_in == DPA_CMD_WR);
    ap = req_addr_in[DPA_AP_BIT];
    req_ready_out = &ok_b;
    go = req_valid_in && req_ready_out;
  end
  function automatic logic [DPA_CNT_W-1:0] dpa_max(input logic [DPA_CNT_W-1:0] a,
    input logic [DPA_CNT_W-1:0] b);
    dpa_max = (a > b) ? a : b;
  endfunction
  genvar g;
  generate
    for (g = 0; g < DPA_BANKS; g++)
    begin : g_bank
      logic sel;
      always_comb
      begin
        sel = (req_ba_in == DPA_BA_W'(g));
        ok_b[g] = 1'b1;
        if (is_pre && (ap || sel) && (pre_reg[g] != DPA_CNT_ZERO))
          ok_b[g] = 1'b0;
        if (is_act && sel && (act_reg[g] != DPA_CNT_ZERO))
          ok_b[g] = 1'b0;
        if (is_pre && (ap || sel) && link.ap_pending[g])
          ok_b[g] = 1'b0;
        pre_next[g] = (pre_reg[g] != DPA_CNT_ZERO) ? pre_reg[g] - DPA_CNT_ONE : pre_reg[g];
        act_next[g] = (act_reg[g] != DPA_CNT_ZERO) ? act_reg[g] - DPA_CNT_ONE : act_reg[g];
        if (go && is_act && sel)
        begin
          pre_next[g] = C_RAS;
          act_next[g] = C_RC;
        end
        if (go && is_rd && sel)
        begin
          pre_next[g] = dpa_max(pre_next[g], C_RD2PRE);
          if (ap)
            act_next[g] = dpa_max(act_next[g], C_RDAP);
        end
        if (go && is_wr && sel)
        begin
          pre_next[g] = dpa_max(pre_next[g], C_WR2PRE);
          if (ap)
            act_next[g] = dpa_max(act_next[g], C_WRAP);
        end
        if (go && is_pre && (ap || sel))
          act_next[g] = dpa_max(act_next[g], C_RP);
      end
      always_ff @(posedge sys_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          pre_reg[g] <= DPA_CNT_ZERO;
          act_reg[g] <= DPA_CNT_ZERO;
        end
        else
        begin
          pre_reg[g] <= pre_next[g];
          act_reg[g] <= act_next[g];
        end
      end
    end
  endgenerate
  // ==========================================================
  // registered command drive
  logic [3:0] cmd_reg, cmd_next;
  logic [DPA_BA_W-1:0] ba_reg, ba_next;
  logic [DPA_ADDR_W-1:0] addr_reg, addr_next;
  always_comb
  begin
    cmd_next = go ? req_cmd_in : DPA_CMD_NOP;
    ba_next = go ? req_ba_in : ba_reg;
    addr_next = go ? req_addr_in : addr_reg;
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmd_reg <= DPA_CMD_NOP;
      ba_reg <= '0;
      addr_reg <= '0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      ba_reg <= ba_next;
      addr_reg <= addr_next;
    end
  end
  assign link.cmd = cmd_reg;
  assign link.ba = ba_reg;
  assign link.addr = addr_reg;
endmodule

// File: verif/dpa_link_chk.sv
`timescale 1ns/10ps
module dpa_link_chk
  import dpa_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // link
  input wire logic [3:0] cmd,
  input wire logic [DPA_BA_W-1:0] ba,
  input wire logic [DPA_ADDR_W-1:0] addr,
  input wire logic [DPA_BANKS-1:0] bank_open,
  input wire logic [DPA_BANKS-1:0] ap_pending,
  input wire logic cmd_error
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // helpers
  logic ap;
  logic col;
  logic rdy;
  assign ap = addr[DPA_AP_BIT];
  assign col = cmd == DPA_CMD_RD || cmd == DPA_CMD_WR;
  assign rdy = bank_open[ba] && !ap_pending[ba];
  // ==========================================================
  // assertions
  pre_one_a: assert property (cmd == DPA_CMD_PRE && !ap |=> !bank_open[$past(ba)])
    else $error("single precharge missed bank");
  pre_all_a: assert property (cmd == DPA_CMD_PRE && ap |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  act_open_a: assert property (cmd == DPA_CMD_ACT |=> bank_open[$past(ba)])
    else $error("activate did not open bank");
  plain_keep_a: assert property (
    col && !ap && rdy |=> bank_open[$past(ba)] && !ap_pending[$past(ba)])
    else $error("plain access closed bank");
  ap_arm_a: assert property (col && ap && rdy |=> ap_pending[$past(ba)])
    else $error("auto precharge not armed");
  rd_ap_time_a: assert property (
    cmd == DPA_CMD_RD && ap && rdy && ba == 2'h0 |=> bank_open[0] [*2] ##1 !bank_open[0])
    else $error("read auto precharge timing");
  wr_ap_time_a: assert property (
    cmd == DPA_CMD_WR && ap && rdy && ba == 2'h0 |=> bank_open[0] [*5] ##1 !bank_open[0])
    else $error("write auto precharge timing");
  ap_clear_a: assert property ($rose(ap_pending[1]) |-> ##[1:8] !ap_pending[1])
    else $error("auto precharge never started");
  no_error_a: assert property (!cmd_error)
    else $error("controller broke a spacing");
endmodule

// File: verif/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
  begin \
    tests_run++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, ex, gt); \
    end \
  end
module tb_top;
  import dpa_pkg::*;
  logic sys_clk_in;
  logic arst_n_in;
  logic req_valid_in;
  logic [3:0] req_cmd_in;
  logic [1:0] req_ba_in;
  logic [12:0] req_addr_in;
  logic req_ready_out;
  logic [3:0] bank_open_out, fb_open, exp_open;
  logic cmd_error_out, fb_err;
  logic main_err_seen = 1'b0;
  logic [3:0] pick [3] = '{DPA_CMD_RD, DPA_CMD_WR, DPA_CMD_PRE};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  dpa_link_if link_main ();
  dpa_link_if link_fault ();
  dpa_ctrl dpa_ctrl_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_ba_in(req_ba_in),
    .req_addr_in(req_addr_in), .req_ready_out(req_ready_out), .link(link_main));
  dpa_sdram_bank dpa_sdram_bank_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .link(link_main), .bank_open_out(bank_open_out), .precharging_out(),
    .cmd_error_out(cmd_error_out));
  // far end driven by the bench so spacing faults can be injected
  dpa_sdram_bank dpa_sdram_bank_fault_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .link(link_fault), .bank_open_out(fb_open), .precharging_out(), .cmd_error_out(fb_err));
  dpa_link_chk dpa_link_chk_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .cmd(link_main.cmd), .ba(link_main.ba), .addr(link_main.addr),
    .bank_open(link_main.bank_open), .ap_pending(link_main.ap_pending),
    .cmd_error(link_main.cmd_error));
  // ==========================================================
  // expectation model
  function automatic logic [3:0] next_open(logic [3:0] o, logic [3:0] c, logic [1:0] b,
    logic ap);
    logic [3:0] m;
    m = 4'h1 << b;
    if (c == DPA_CMD_ACT) return o | m;
    if (c == DPA_CMD_PRE && ap) return 4'h0;
    if (c == DPA_CMD_PRE || ap) return o & ~m;
    return o;
  endfunction
  // ==========================================================
  // tasks
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic ap,
    input int settle);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    req_valid_in <= 1'b1;
    req_cmd_in <= c;
    req_ba_in <= b;
    req_addr_in <= (13'($urandom) & 13'h1BFF) | (ap ? 13'h0400 : 13'h0000);
    @(negedge sys_clk_in);
    while (req_ready_out !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge sys_clk_in);
    end
    @(posedge sys_clk_in);
    req_valid_in <= 1'b0;
    @(negedge sys_clk_in);
    `CHK("link_cmd", c, link_main.cmd)
    `CHK("link_ba", b, link_main.ba)
    exp_open = next_open(exp_open, c, b, ap);
    repeat (settle) @(negedge sys_clk_in);
    if (settle > 0) `CHK("bank_open", exp_open, bank_open_out)
  endtask
  task automatic fcmd(input logic [3:0] c, input logic [1:0] b, input logic ap);
    @(posedge sys_clk_in);
    link_fault.cmd <= c;
    link_fault.ba <= b;
    link_fault.addr <= ap ? 13'h0400 : 13'h0000;
    @(posedge sys_clk_in);
    link_fault.cmd <= DPA_CMD_NOP;
    link_fault.ba <= ~b;
    link_fault.addr <= 13'($urandom);
    @(negedge sys_clk_in);
  endtask
  task automatic watch_err(input logic ex);
    logic seen;
    seen = fb_err;
    repeat (3)
    begin
      @(negedge sys_clk_in);
      seen = seen | fb_err;
    end
    `CHK("cmd_error", ex, seen)
  endtask
  // ==========================================================
  // clock, timeout, main sequence
  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  always @(negedge sys_clk_in)
  begin
    if (cmd_error_out === 1'b1)
      main_err_seen <= 1'b1;
  end
  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    logic [1:0] b;
    arst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_cmd_in = DPA_CMD_NOP;
    req_ba_in = 2'h0;
    req_addr_in = 13'h0000;
    link_fault.cmd = DPA_CMD_NOP;
    link_fault.ba = 2'h0;
    link_fault.addr = 13'h0000;
    exp_open = 4'h0;
    void'($urandom(32'h340A));
    repeat (10) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    issue(DPA_CMD_ACT, 2'h0, 1'b0, 8);
    issue(DPA_CMD_RD, 2'h0, 1'b1, 8);
    issue(DPA_CMD_ACT, 2'h0, 1'b0, 8);
    issue(DPA_CMD_WR, 2'h0, 1'b1, 8);
    issue(DPA_CMD_ACT, 2'h0, 1'b0, 8);
    issue(DPA_CMD_RD, 2'h0, 1'b0, 8);
    issue(DPA_CMD_ACT, 2'h1, 1'b0, 0);
    issue(DPA_CMD_PRE, 2'h3, 1'b1, 0);
    issue(DPA_CMD_PRE, 2'h1, 1'b0, 8);
    for (int k = 0; k < 150; k++)
    begin
      b = 2'($urandom);
      issue(exp_open[b] ? pick[$urandom % 3] : DPA_CMD_ACT, b, 1'($urandom), 8);
    end
    `CHK("main_error", 1'b0, main_err_seen)
    for (int i = 0; i < 4; i++) fcmd(DPA_CMD_ACT, 2'(i), 1'b0);
    `CHK("fault_open", 4'hF, fb_open)
    for (int i = 0; i < 4; i++)
    begin
      fcmd(DPA_CMD_PRE, 2'(i), 1'b0);
      `CHK("fault_open", 4'(4'hF << (i + 1)), fb_open)
    end
    fcmd(DPA_CMD_ACT, 2'h0, 1'b0);
    fcmd(DPA_CMD_ACT, 2'h2, 1'b0);
    fcmd(DPA_CMD_PRE, 2'h1, 1'b1);
    `CHK("fault_open", 4'h0, fb_open)
    fcmd(DPA_CMD_ACT, 2'h3, 1'b0);
    fcmd(DPA_CMD_RD, 2'h3, 1'b0);
    fcmd(DPA_CMD_PRE, 2'h3, 1'b0);
    watch_err(1'b0);
    fcmd(DPA_CMD_ACT, 2'h1, 1'b0);
    fcmd(DPA_CMD_WR, 2'h1, 1'b0);
    fcmd(DPA_CMD_PRE, 2'h1, 1'b0);
    watch_err(1'b1);
    fcmd(DPA_CMD_RD, 2'h2, 1'b0);
    watch_err(1'b1);
    report_and_stop();
  end
endmodule
